// ---- rtl/hap_pkg.sv ----
// Constants for the haptic driver register bank
// Functional notes
// [R01] Drive config bit 7: 0 power-down, 1 normal drive.
// [R02] Drive config bit 6: over-drive off/on, meant for ERM.
// [R03] Drive config bit 5: over-drive rail, 0 ground brake, 1 supply.
// [R04] Drive config bit 4: 0 resonant actuator, 1 rotating mass motor.
// [R05] Drive config bits 1:0: PWM divide by 1, 128, 256, 512.
// [R06] Drive config bits 3:2 and level config bits 1:0 unused.
// [R07] Level config bits 7:5: input resistance 8 to 22 kohm, default 001.
// [R08] Level config bits 4:2: regulator level 2.4-3.6 V, default 011, 111 undefined.
// [R09] Status bit 3: 1 when supply valid, 0 under undervoltage.
// [R10] Status bit 2: 1 when regulator output valid, 0 below 70 percent.
// [R11] Status bit 1 active low: 0 while thermal protection tripped.
// [R12] Status bits 7:4 and 0 reserved; bit 0 reads 0.
// [R13] Status register read-only, resets to 0000_1110.
// [R14] Drive config resets 1001_0000, level config resets 0010_1100.
// [R15] Defaults load at power-up; works with serial pins unconnected.
// [R16] Resonant mode divides 10-50 kHz PWM by programmed ratio.
// [R17] Drive amplitude follows duty; half duty stops motor.
// [R18] Vibration maximal at 1 percent and 99 percent duty.
// [R19] Bus address 0000110 plus read/write bit.
// [R20] Register pointer advances by one after each data byte; the code leaves it unchanged after a read byte the host NACKs.
// [R21] Host sends pointer byte before every write.
// [R22] Pointer set without repeated start: following bytes are write data.
// [R23] Writes to status or undefined addresses change nothing.
package hap_pkg;
  localparam logic [6:0] DEV_ADDR     = 7'h06;
  localparam logic [7:0] DRIVE_OFS    = 8'h20;
  localparam logic [7:0] LEVEL_OFS    = 8'h21;
  localparam logic [7:0] HEALTH_OFS   = 8'h22;
  localparam logic [7:0] DRIVE_RST    = 8'h90;
  localparam logic [7:0] LEVEL_RST    = 8'h2c;
  localparam logic [7:0] HEALTH_RST   = 8'h0e;
  localparam logic [7:0] DRIVE_MASK   = 8'hf3;
  localparam logic [7:0] LEVEL_MASK   = 8'hfc;
  localparam int         EN_BIT       = 7;
  localparam int         OD_BIT       = 6;
  localparam int         RAIL_BIT     = 5;
  localparam int         KIND_BIT     = 4;
  localparam int         DIV_LSB      = 0;
  localparam int         RES_LSB      = 5;
  localparam int         REG_LSB      = 2;
  localparam int         SUP_BIT      = 3;
  localparam int         RGOOD_BIT    = 2;
  localparam int         THERM_BIT    = 1;
  localparam logic [2:0] REG_UNDEF    = 3'h7;
  localparam logic [9:0] DIV128_M1    = 10'h07f;
  localparam logic [9:0] DIV256_M1    = 10'h0ff;
  localparam logic [9:0] DIV512_M1    = 10'h1ff;
  localparam logic [1:0] DIV_ONE      = 2'h0;
  localparam logic [1:0] DIV_128      = 2'h1;
  localparam logic [1:0] DIV_256      = 2'h2;
endpackage

// ---- rtl/hap_pwm_div.sv ----
// PWM input divider for resonant actuator mode
`timescale 1ns/1ps
module hap_pwm_div
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic [1:0] div_sel,
  input  wire logic       pwm_in,
  // Result
  output logic            pwm_out
);
  logic       pwm_d_reg;
  logic [9:0] cnt_reg;
  logic [9:0] term;

  always_comb
  begin
    case (div_sel)
      hap_pkg::DIV_128: term = hap_pkg::DIV128_M1;
      hap_pkg::DIV_256: term = hap_pkg::DIV256_M1;
      default:          term = hap_pkg::DIV512_M1;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pwm_d_reg <= 1'b0;
    else
      pwm_d_reg <= pwm_in;
  end

  // Output toggles every half ratio of input rising edges
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= 10'h000;
      pwm_out <= 1'b0;
    end
    else if (div_sel == hap_pkg::DIV_ONE)
    begin
      cnt_reg <= 10'h000;
      pwm_out <= pwm_in; // R05
    end
    else if (pwm_in && !pwm_d_reg)
    begin
      if (cnt_reg >= (term >> 1))
      begin
        cnt_reg <= 10'h000;
        pwm_out <= !pwm_out; // R16
      end
      else
        cnt_reg <= cnt_reg + 10'h001;
    end
  end
endmodule // hap_pwm_div

// ---- rtl/hap_i2c_rx.sv ----
// I2C bus line sampler: start, stop and clock edge detection
`timescale 1ns/1ps
module hap_i2c_rx
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Bus lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Events
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      sda_now
);
  logic scl_q_reg;
  logic sda_q_reg;

  // Idle high so floating pins never fake a start
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end
    else
    begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
    end
  end

  assign sda_now   = sda_q_reg;
  assign scl_rise  = scl_in && !scl_q_reg;
  assign scl_fall  = !scl_in && scl_q_reg;
  assign start_det = scl_in && scl_q_reg && !sda_in && sda_q_reg;
  assign stop_det  = scl_in && scl_q_reg && sda_in && !sda_q_reg;
endmodule // hap_i2c_rx

// ---- rtl/hap_regbank.sv ----
// Haptic driver register bank with I2C slave port
`timescale 1ns/1ps
module hap_regbank
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // I2C pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Analog monitors
  input  wire logic       supply_ok,
  input  wire logic       regulator_good,
  input  wire logic       thermal_ok,
  // PWM path
  input  wire logic       pwm_in,
  output logic            pwm_drive,
  // Configuration to analog
  output logic            drive_on,
  output logic            overdrive_on,
  output logic            overdrive_rail_sel,
  output logic            actuator_kind,
  output logic [1:0]      pwm_div_sel,
  output logic [2:0]      input_res_sel,
  output logic [2:0]      regulator_level_sel
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_PTR  = 5'h04,
    ST_WDAT = 5'h08,
    ST_RDAT = 5'h10
  } hap_state_t;

  hap_state_t state_reg;
  logic [7:0] drive_config_reg;
  logic [7:0] level_config_reg;
  logic [7:0] health_reg;
  logic [7:0] ptr_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic       rw_reg;
  logic       ack_phase_reg;
  logic       nack_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sda_now;
  logic [7:0] rbyte;
  logic       raw_pwm;
  logic       byte_end;
  logic       ack_end;
  logic       addr_hit;
  logic       oe_next;
  logic [7:0] rbyte_nxt;
  hap_state_t state_next;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] d,
                                          input logic [7:0] l, input logic [7:0] h);
    case (a)
      hap_pkg::DRIVE_OFS:  read_mux = d;
      hap_pkg::LEVEL_OFS:  read_mux = l;
      hap_pkg::HEALTH_OFS: read_mux = h;
      default:             read_mux = 8'h00;
    endcase
  endfunction

  hap_i2c_rx u_rx
  (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_now   (sda_now)
  );

  assign rbyte     = read_mux(ptr_reg, drive_config_reg, level_config_reg, health_reg);
  // Next byte's MSB leaves on the same edge that steps the pointer
  assign rbyte_nxt = read_mux(ptr_reg + 8'h01, drive_config_reg, level_config_reg,
                              health_reg);

  // SCL falls that close the eighth bit and the acknowledge slot
  assign byte_end  = scl_fall && bit_reg == 4'h8 && !ack_phase_reg;
  assign ack_end   = scl_fall && ack_phase_reg;
  assign addr_hit  = shift_reg[7:1] == hap_pkg::DEV_ADDR; // R19

  // Bit counter: 0..7 data, 8 acknowledge slot
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_reg   <= 4'h0;
      shift_reg <= 8'h00;
    end
    else if (start_det || stop_det)
    begin
      bit_reg   <= 4'h0;
    end
    else if (scl_rise && bit_reg < 4'h8)
    begin
      shift_reg <= {shift_reg[6:0], sda_now};
      bit_reg   <= bit_reg + 4'h1;
    end
    else if (scl_fall && ack_phase_reg)
      bit_reg   <= 4'h0;
  end

  // Acknowledge slot begins after eighth bit falls
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_phase_reg <= 1'b0;
    else if (start_det || stop_det)
      ack_phase_reg <= 1'b0;
    else if (scl_fall && bit_reg == 4'h8)
      ack_phase_reg <= !ack_phase_reg;
  end

  // Master acknowledge on read byte, sampled in the slot
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      nack_reg <= 1'b0;
    else if (start_det)
      nack_reg <= 1'b0;
    else if (scl_rise && ack_phase_reg && state_reg == ST_RDAT)
      nack_reg <= sda_now;
  end

  // Transaction state; moves at end of each acknowledge slot
  always_comb
  begin
    state_next = state_reg;
    if (start_det)
      state_next = ST_ADDR; // R22
    else if (stop_det)
      state_next = ST_IDLE;
    else if (byte_end && state_reg == ST_ADDR && !addr_hit)
      state_next = ST_IDLE; // R19
    else if (ack_end)
    begin
      case (state_reg)
        ST_ADDR:  state_next = rw_reg ? ST_RDAT : ST_PTR;
        ST_PTR:   state_next = ST_WDAT; // R21
        ST_WDAT:  state_next = ST_WDAT;
        ST_RDAT:  state_next = nack_reg ? ST_IDLE : ST_RDAT;
        default:  state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Direction bit taken with the address byte, matched or not
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rw_reg <= 1'b0;
    else if (byte_end && state_reg == ST_ADDR)
      rw_reg <= shift_reg[0];
  end

  // Pointer load and auto increment
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ptr_reg <= hap_pkg::DRIVE_OFS;
    else if (scl_fall && bit_reg == 4'h8 && !ack_phase_reg)
    begin
      if (state_reg == ST_PTR)
        ptr_reg <= shift_reg;
      else if (state_reg == ST_WDAT)
        ptr_reg <= ptr_reg + 8'h01; // R20
    end
    else if (scl_fall && ack_phase_reg && state_reg == ST_RDAT && !nack_reg)
      ptr_reg <= ptr_reg + 8'h01; // R20
  end

  // Writable registers; reserved bits held at zero
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drive_config_reg <= hap_pkg::DRIVE_RST; // R14 R15
      level_config_reg <= hap_pkg::LEVEL_RST; // R14 R15
    end
    else if (scl_fall && bit_reg == 4'h8 && !ack_phase_reg && state_reg == ST_WDAT)
    begin
      if (ptr_reg == hap_pkg::DRIVE_OFS)
        drive_config_reg <= shift_reg & hap_pkg::DRIVE_MASK; // R06
      else if (ptr_reg == hap_pkg::LEVEL_OFS)
        level_config_reg <= shift_reg & hap_pkg::LEVEL_MASK; // R06
      // Status and unmapped pointers are silently dropped
    end // R23
  end

  // Status snapshot; software cannot write it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      health_reg <= hap_pkg::HEALTH_RST; // R13
    else
    begin
      health_reg <= 8'h00; // R12
      health_reg[hap_pkg::SUP_BIT]   <= supply_ok; // R09
      health_reg[hap_pkg::RGOOD_BIT] <= regulator_good; // R10
      health_reg[hap_pkg::THERM_BIT] <= thermal_ok; // R11
    end
  end

  // Open-drain SDA: ack slots and read data bits, changed only after SCL falls
  always_comb
  begin
    oe_next = sda_oe;
    if (start_det || stop_det)
      oe_next = 1'b0;
    else if (byte_end)
      oe_next = (state_reg == ST_ADDR && addr_hit) || state_reg == ST_PTR
                || state_reg == ST_WDAT;
    else if (ack_end && state_reg == ST_ADDR)
      oe_next = rw_reg && !rbyte[7];
    else if (ack_end && state_reg == ST_RDAT)
      oe_next = !nack_reg && !rbyte_nxt[7]; // R20
    else if (ack_end)
      oe_next = 1'b0;
    else if (scl_fall && state_reg == ST_RDAT && bit_reg < 4'h8)
      oe_next = !rbyte[3'h7 - bit_reg[2:0]];
    else if (scl_fall)
      oe_next = 1'b0;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sda_oe <= 1'b0;
    else
      sda_oe <= oe_next;
  end

  assign sda_out = 1'b0;

  assign drive_on            = drive_config_reg[hap_pkg::EN_BIT]; // R01
  assign overdrive_on        = drive_config_reg[hap_pkg::OD_BIT]; // R02
  assign overdrive_rail_sel  = drive_config_reg[hap_pkg::RAIL_BIT]; // R03
  assign actuator_kind       = drive_config_reg[hap_pkg::KIND_BIT]; // R04
  assign pwm_div_sel         = drive_config_reg[hap_pkg::DIV_LSB +: 2]; // R05
  assign input_res_sel       = level_config_reg[hap_pkg::RES_LSB +: 3]; // R07
  assign regulator_level_sel = level_config_reg[hap_pkg::REG_LSB +: 3]; // R08

  hap_pwm_div u_div
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .div_sel  (actuator_kind ? hap_pkg::DIV_ONE : pwm_div_sel),
    .pwm_in   (pwm_in),
    .pwm_out  (raw_pwm)
  );

  // Duty carries amplitude downstream; power-down parks at midpoint-free low
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pwm_drive <= 1'b0;
    else
      pwm_drive <= drive_on && raw_pwm; // R17 R18
  end
endmodule // hap_regbank

// ---- test/hap_regbank_assertions.sv ----
// Port checker for the haptic register bank
`timescale 1ns/1ps
module hap_regbank_chk
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Bus
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // PWM path
  input wire logic       pwm_in,
  input wire logic       pwm_drive,
  // Fields
  input wire logic       drive_on,
  input wire logic       overdrive_on,
  input wire logic       overdrive_rail_sel,
  input wire logic       actuator_kind,
  input wire logic [1:0] pwm_div_sel,
  input wire logic [2:0] input_res_sel,
  input wire logic [2:0] regulator_level_sel
);
  logic [11:0] flds;
  assign flds = {drive_on, overdrive_on, overdrive_rail_sel, actuator_kind,
                 pwm_div_sel, input_res_sel, regulator_level_sel};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_sda_never_high: assert property (sda_out == 1'b0)
    else $error("sda_out high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved with scl high");
  a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe[*3])
    else $error("sda_oe pulse too short");
  a_cfg_scl_low: assert property ($changed(flds) |-> !scl_in)
    else $error("field moved with scl high");
  a_reset_dflt: assert property ($rose(arst_n) |-> flds == 12'h90b)
    else $error("fields not at defaults after reset");
  a_off_quiet: assert property (!drive_on |=> !pwm_drive)
    else $error("pwm_drive active in power-down");
  a_erm_rise: assert property ($rose(pwm_in) && actuator_kind && drive_on |-> ##[1:2] pwm_drive)
    else $error("pwm_drive missed a rise");
  a_erm_fall: assert property ($fell(pwm_in) && actuator_kind |-> ##[1:2] !pwm_drive)
    else $error("pwm_drive missed a fall");
endmodule // hap_regbank_chk

// ---- test/hap_i2c_host.sv ----
// I2C host model: drives SCL, pulls SDA low, returns read bytes
`timescale 1ns/1ps
module hap_i2c_host
(
  // Clock
  input  wire logic  core_clk,
  // Bus
  input  wire logic  sda,
  output logic       scl = 1'b1,
  output logic       sda_pull = 1'b0,
  // Read result
  output logic [7:0] rx_byte = 8'h00,
  output logic       rx_done = 1'b0
);
  task automatic hc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Also serves as repeated start, so SDA is released first
  task automatic start();
    sda_pull = 1'b0;
    hc(2);
    scl = 1'b1;
    hc(4);
    sda_pull = 1'b1;
    hc(4);
    scl = 1'b0;
    hc(2);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    hc(2);
    scl = 1'b1;
    hc(4);
    sda_pull = 1'b0;
    hc(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    hc(2);
    scl = 1'b1;
    hc(2);
    r = sda;
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask
  // MSB first, then the ninth clock for the acknowledge
  task automatic xfer(input logic [7:0] d, input logic fin, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(fin, ack);
  endtask
  task automatic rd(input logic nack);
    logic [7:0] q;
    logic       a;
    xfer(8'hff, nack, q, a);
    rx_byte = q;
    rx_done = 1'b1;
    hc(1);
    rx_done = 1'b0;
  endtask
endmodule // hap_i2c_host

// ---- test/tb.sv ----
// Self-checking bench for the haptic register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
  logic core_clk = 1'b0, arst_n = 1'b0, pwm_in = 1'b0, pwm_run = 1'b0, cnt_en = 1'b0;
  logic supply_ok = 1'b1, regulator_good = 1'b1, thermal_ok = 1'b1;
  logic scl, sda_pull, rx_done, sda_out, sda_oe, pwm_drive, drive_on, overdrive_on;
  logic overdrive_rail_sel, actuator_kind, pwm_q;
  logic [1:0] pwm_div_sel;
  logic [2:0] input_res_sel, regulator_level_sel, pc = 3'h0;
  logic [7:0] rx_byte, sb_exp;
  logic [7:0] exp_q[$];
  int bad_count = 0, comparisons = 0, seed = 32'h4607, rises = 0;
  wire sda = !(sda_pull | sda_oe);
  wire [11:0] flds = {drive_on, overdrive_on, overdrive_rail_sel, actuator_kind,
                      pwm_div_sel, input_res_sel, regulator_level_sel};
  hap_regbank hap_regbank_i (.core_clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .supply_ok, .regulator_good, .thermal_ok, .pwm_in, .pwm_drive, .drive_on,
    .overdrive_on, .overdrive_rail_sel, .actuator_kind, .pwm_div_sel, .input_res_sel,
    .regulator_level_sel);
  hap_i2c_host hap_i2c_host_i (.core_clk, .sda, .scl, .sda_pull, .rx_byte, .rx_done);
  always #20 core_clk = ~core_clk;
  always @(negedge core_clk)
  begin
    pc <= pwm_run ? pc + 3'h1 : 3'h0;
    pwm_in <= pwm_run && pc < 3'h2;
  end
  always @(posedge core_clk)
  begin
    if (cnt_en && pwm_drive && !pwm_q)
      rises++;
    pwm_q <= pwm_drive;
  end
  always @(posedge rx_done)
  begin
    sb_exp = exp_q.pop_front();
    `CHK("read byte", sb_exp, rx_byte)
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic addr_ptr(input logic [6:0] dev, input logic [7:0] ptr, input logic ea);
    logic [7:0] q;
    logic       a;
    hap_i2c_host_i.start();
    hap_i2c_host_i.xfer({dev, 1'b0}, 1'b1, q, a);
    `CHK("address ack", ea, a)
    hap_i2c_host_i.xfer(ptr, 1'b1, q, a);
    `CHK("pointer ack", ea, a)
  endtask
  task automatic wr(input logic [7:0] ptr, input int n, input logic [23:0] d);
    logic [7:0] q;
    logic       a;
    addr_ptr(hap_pkg::DEV_ADDR, ptr, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      hap_i2c_host_i.xfer(d[23-8*i -: 8], 1'b1, q, a);
      `CHK("data ack", 1'b0, a)
    end
    hap_i2c_host_i.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n, input logic [23:0] e);
    logic [7:0] q;
    logic       a;
    addr_ptr(hap_pkg::DEV_ADDR, ptr, 1'b0);
    hap_i2c_host_i.start();
    hap_i2c_host_i.xfer({hap_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a);
    `CHK("read ack", 1'b0, a)
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(e[23-8*i -: 8]);
      hap_i2c_host_i.rd(i == n - 1);
    end
    hap_i2c_host_i.stop();
  endtask
  initial
  begin
    #3_000_000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    logic [7:0]  d0, d1, q;
    logic [11:0] ef;
    logic        a;
    logic [7:0]  code [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h93, 8'h13};
    int          ratio [6] = '{1, 128, 256, 512, 1, 1};
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    `CHK("defaults", 12'h90b, flds)
    rd(8'h20, 3, {hap_pkg::DRIVE_RST, hap_pkg::LEVEL_RST, hap_pkg::HEALTH_RST});
    for (int k = 0; k < 2; k++)
    begin
      d0 = $random(seed);
      d1 = $random(seed);
      wr(8'h20, 3, {d0, d1, 8'hff});
      ef = {d0[7:4], d0[1:0], d1[7:2]};
      `CHK("fields", ef, flds)
      rd(8'h20, 3, {d0 & 8'hf3, d1 & 8'hfc, 8'h0e});
    end
    for (int i = 0; i < 8; i++)
    begin
      {supply_ok, regulator_good, thermal_ok} = i[2:0];
      rd(8'h22, 1, {4'h0, i[2:0], 1'b0, 16'h0});
    end
    {supply_ok, regulator_good, thermal_ok} = 3'h7;
    addr_ptr(7'h07, 8'h20, 1'b1);
    hap_i2c_host_i.xfer(8'h00, 1'b1, q, a);
    hap_i2c_host_i.stop();
    wr(8'h30, 1, {8'h55, 16'h0});
    rd(8'h30, 1, 24'h0);
    `CHK("fields kept", ef, flds)
    for (int j = 0; j < 6; j++)
    begin
      wr(8'h20, 1, {code[j], 16'h0});
      pwm_run = 1'b1;
      repeat (8 * ratio[j]) @(negedge core_clk);
      rises = 0;
      cnt_en = 1'b1;
      repeat (16 * ratio[j]) @(negedge core_clk);
      cnt_en = 1'b0;
      pwm_run = 1'b0;
      `CHK("pwm rises", (j < 5) ? 2 : 0, rises)
    end
    `CHK("pending reads", 0, exp_q.size())
    complete_run();
  end
endmodule // tb
bind hap_regbank hap_regbank_chk hap_regbank_chk_i (.*);
